// File: rtl/sfr_pkg.sv
// Constants for the serial-loaded fractional synthesizer register bank.
package sfr_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 20;
  localparam int NUM_W = 22;
  localparam int REG_CNT = 16;
  // Addresses that own storage; the hidden ones are accepted on the wire and dropped.
  localparam logic [15:0] REG_MAP = 16'h13ff;
  localparam logic [3:0] ADDR_R0 = 4'h0;
  localparam logic [3:0] ADDR_R1 = 4'h1;
  localparam logic [3:0] ADDR_R2 = 4'h2;
  localparam logic [3:0] ADDR_R3 = 4'h3;
  localparam logic [3:0] ADDR_R4 = 4'h4;
  localparam logic [3:0] ADDR_R5 = 4'h5;
  localparam logic [3:0] ADDR_R6 = 4'h6;
  localparam logic [3:0] ADDR_R7 = 4'h7;
  localparam logic [3:0] ADDR_R8 = 4'h8;
  localparam logic [3:0] ADDR_R9 = 4'h9;
  localparam logic [3:0] ADDR_R12 = 4'hc;
  // Field positions are word bit positions; subtract DATA_LSB to index stored data.
  localparam int DATA_LSB = 4;
  localparam int NUM_LO_LSB = 4;
  localparam int NUM_LO_W = 12;
  localparam int INT_LO_LSB = 16;
  localparam int INT_LO_W = 8;
  localparam int NUM_HI_LSB = 4;
  localparam int NUM_HI_W = 10;
  localparam int INT_HI_LSB = 14;
  localparam int INT_HI_W = 3;
  localparam int PUMP_LSB = 17;
  localparam int PUMP_W = 4;
  localparam int PRESC_BIT = 21;
  localparam int REFDIV_LSB = 4;
  localparam int REFDIV_W = 6;
  localparam int DEN_LO_LSB = 10;
  localparam int DEN_LO_W = 12;
  localparam int DEN_HI_LSB = 4;
  localparam int DEN_HI_W = 10;
  localparam int WIDE_BIT = 22;
  localparam int HALVE_BIT = 23;
  localparam logic [5:0] REFDIV_LIM1 = 6'h08;
  localparam logic [5:0] REFDIV_LIM2 = 6'h10;
  localparam logic [5:0] REFDIV_LIM3 = 6'h20;
  localparam logic [DATA_W-1:0] DATA_RST = '0;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_SHIFT = 2'b10
  } sfr_state_t;
endpackage

// File: rtl/sfr_regmap.sv
// Serial-programmed register bank with numerator assembly and calibration start.
`timescale 1ns/1ps
module sfr_regmap
  import sfr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe,
  output logic cal_start,
  output logic [NUM_W-1:0] frac_numerator,
  output logic [NUM_W-1:0] frac_denominator,
  output logic wide_fraction_select,
  output logic [REFDIV_W-1:0] ref_divider,
  output logic [INT_LO_W+INT_HI_W-1:0] int_divider,
  output logic [PUMP_W-1:0] pump_gain,
  output logic prescaler_select,
  output logic output_halving_select,
  output logic num_restrict_err,
  output logic [DATA_W-1:0] fastlock_timeout_word,
  output logic [DATA_W-1:0] power_enable_word,
  output logic [DATA_W-1:0] loop_filter_vco_word,
  output logic [DATA_W-1:0] crystal_divider_word,
  output logic [DATA_W-1:0] misc_option_word,
  output logic [DATA_W-1:0] lock_detect_option_word,
  output logic [DATA_W-1:0] factory_setting_word
);

  // Pin synchronisers. The third stage only serves edge detection.
  logic [2:0] sclk_r;
  logic [2:0] lat_r;
  logic [1:0] sdat_r;
  logic [2:0] sclk_nxt;
  logic [2:0] lat_nxt;
  logic [1:0] sdat_nxt;

  always_comb begin
    sclk_nxt = {sclk_r[1:0], serial_clk};
    lat_nxt = {lat_r[1:0], latch_strobe};
    sdat_nxt = {sdat_r[0], serial_data};
  end

  // The strobe idles high, so its history resets high. A low reset value would show
  // a rising edge on release and commit a stale word to register zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_r <= '0;
      lat_r <= '1;
      sdat_r <= '0;
    end else begin
      sclk_r <= sclk_nxt;
      lat_r <= lat_nxt;
      sdat_r <= sdat_nxt;
    end
  end

  logic sclk_rise;
  logic commit;
  assign sclk_rise = sclk_r[1] & ~sclk_r[2];
  assign commit = lat_r[1] & ~lat_r[2];

  // Shift state: bits are only accepted while the strobe is low.
  sfr_state_t st_r;
  sfr_state_t st_nxt;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;

  always_comb begin
    st_nxt = st_r;
    shift_nxt = shift_r;
    case (st_r)
      ST_HOLD: begin
        if (!lat_r[1]) begin
          st_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (lat_r[1]) begin
          st_nxt = ST_HOLD;
        end else if (sclk_rise) begin
          shift_nxt = {shift_r[WORD_W-2:0], sdat_r[1]};
        end
      end
      default: begin
        st_nxt = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= ST_HOLD;
      shift_r <= '0;
    end else begin
      st_r <= st_nxt;
      shift_r <= shift_nxt;
    end
  end

  // Register storage. A strobe edge always moves the data field; a hidden
  // address is accepted on the wire but has nowhere to land.
  logic [DATA_W-1:0] reg_r [REG_CNT];
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  assign wr_addr = shift_r[ADDR_W-1:0];
  assign wr_data = shift_r[WORD_W-1:DATA_LSB];

  for (genvar g = 0; g < REG_CNT; g++) begin : g_reg
    if (REG_MAP[g]) begin : g_store
      logic [DATA_W-1:0] reg_nxt;
      always_comb begin
        reg_nxt = reg_r[g];
        if (commit && wr_addr == ADDR_W'(g)) begin
          reg_nxt = wr_data;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          reg_r[g] <= DATA_RST;
        end else begin
          reg_r[g] <= reg_nxt;
        end
      end
    end else begin : g_hidden
      assign reg_r[g] = DATA_RST;
    end
  end

  // Fraction, width, calibration and flag outputs are registered; the other decoded fields come straight from the stored words.
  logic [DATA_W-1:0] w0;
  logic [DATA_W-1:0] w1;
  logic [DATA_W-1:0] w2;
  logic [DATA_W-1:0] w3;
  assign w0 = reg_r[ADDR_R0];
  assign w1 = reg_r[ADDR_R1];
  assign w2 = reg_r[ADDR_R2];
  assign w3 = reg_r[ADDR_R3];

  logic cal_r;
  logic cal_nxt;
  logic wide_r;
  logic wide_nxt;
  logic [NUM_W-1:0] num_r;
  logic [NUM_W-1:0] num_nxt;
  logic [NUM_W-1:0] den_r;
  logic [NUM_W-1:0] den_nxt;
  logic err_r;
  logic err_nxt;

  always_comb begin
    cal_nxt = commit && wr_addr == ADDR_R0;
    wide_nxt = w3[WIDE_BIT-DATA_LSB];
    num_nxt = '0;
    num_nxt[NUM_LO_W-1:0] = w0[NUM_LO_LSB-DATA_LSB +: NUM_LO_W];
    den_nxt = '0;
    den_nxt[DEN_LO_W-1:0] = w2[DEN_LO_LSB-DATA_LSB +: DEN_LO_W];
    if (wide_nxt) begin
      num_nxt[NUM_W-1:NUM_LO_W] = w1[NUM_HI_LSB-DATA_LSB +: NUM_HI_W];
      den_nxt[NUM_W-1:DEN_LO_W] = w3[DEN_HI_LSB-DATA_LSB +: DEN_HI_W];
    end
    // Narrow mode leaves the upper numerator at zero.
    // The host is trusted with the low-bit limits; a breach is only flagged.
    err_nxt = (num_r != '0) && (
      (ref_divider > REFDIV_LIM1 && num_r[0]) ||
      (ref_divider > REFDIV_LIM2 && num_r[1]) ||
      (ref_divider > REFDIV_LIM3 && num_r[2]));
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cal_r <= 1'b0;
      wide_r <= 1'b0;
      num_r <= '0;
      den_r <= '0;
      err_r <= 1'b0;
    end else begin
      cal_r <= cal_nxt;
      wide_r <= wide_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
      err_r <= err_nxt;
    end
  end

  assign cal_start = cal_r;
  assign wide_fraction_select = wide_r;
  assign frac_numerator = num_r;
  assign frac_denominator = den_r;
  assign num_restrict_err = err_r;
  assign ref_divider = w2[REFDIV_LSB-DATA_LSB +: REFDIV_W];
  assign int_divider = {w1[INT_HI_LSB-DATA_LSB +: INT_HI_W],
                        w0[INT_LO_LSB-DATA_LSB +: INT_LO_W]};
  assign pump_gain = w1[PUMP_LSB-DATA_LSB +: PUMP_W];
  assign prescaler_select = w1[PRESC_BIT-DATA_LSB];
  assign output_halving_select = w3[HALVE_BIT-DATA_LSB];
  assign fastlock_timeout_word = reg_r[ADDR_R4];
  assign power_enable_word = reg_r[ADDR_R5];
  assign loop_filter_vco_word = reg_r[ADDR_R6];
  assign crystal_divider_word = reg_r[ADDR_R7];
  assign misc_option_word = reg_r[ADDR_R8];
  assign lock_detect_option_word = reg_r[ADDR_R9];
  assign factory_setting_word = reg_r[ADDR_R12];

  // Checks on the behaviour above.
  sequence s_commit_r0;
    commit && wr_addr == ADDR_R0;
  endsequence

  sequence s_commit_r3;
    commit && wr_addr == ADDR_R3;
  endsequence

  sequence s_bit_in;
    st_r == ST_SHIFT && !lat_r[1] && sclk_rise;
  endsequence

  a_cal_launch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_commit_r0 |=> cal_start)
    else $error("calibration not launched after register zero commit");

  a_cal_single: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cal_start |-> $past(commit) && !$past(cal_start) ##1 !cal_start)
    else $error("calibration start pulse not single cycle");

  a_num_low_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_commit_r0 |=> ##1 frac_numerator[NUM_LO_W-1:0] == $past(shift_r[15:4], 2))
    else $error("numerator low bits not taken from register zero");

  a_narrow_num: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !wide_fraction_select |-> frac_numerator[NUM_W-1:NUM_LO_W] == '0)
    else $error("upper numerator bits used in narrow mode");

  a_wide_num: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wide_fraction_select |->
      frac_numerator[NUM_W-1:NUM_LO_W] == $past(w1[NUM_HI_W-1:0]))
    else $error("upper numerator bits missing in wide mode");

  a_wide_bit_pos: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_commit_r3 |=> ##1 wide_fraction_select == $past(shift_r[WIDE_BIT], 2))
    else $error("width select not taken from bit 22 of register three");

  a_word_shift: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_bit_in |=> shift_r == {$past(shift_r[WORD_W-2:0]), $past(sdat_r[1])})
    else $error("serial bit not shifted in MSB first");

  a_hold_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r == ST_HOLD |=> $stable(shift_r))
    else $error("shift register moved while strobe high");

  a_commit_store: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_commit_r3 |=> w3 == $past(wr_data))
    else $error("data field not stored on strobe edge");

endmodule

// File: tb/sfr_host.sv
// Host model that shifts 24-bit programming words into the register bank.
`timescale 1ns/1ps
module sfr_host (
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b1;
  end

  // The serial clock stands low between frames, and the released data line shows the
  // inverse of its last bit so that a late sample of a stale bit cannot pass unnoticed.
  task automatic send(input logic [23:0] w);
    latch_strobe = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #400 serial_clk = 1'b1;
      #400 serial_clk = 1'b0;
    end
    latch_strobe = 1'b1;
    serial_data = ~w[0];
    #800;
  endtask
endmodule

// File: tb/synth_fraction_register_map_test.sv
// Self-checking bench for the serial-loaded synthesizer register bank.
`timescale 1ns/1ps
module synth_fraction_register_map_test;
  import sfr_pkg::*;
  typedef struct packed {
    logic [23:0] w;
    logic [21:0] num;
    logic cal;
  } sfr_row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire serial_clk;
  wire serial_data;
  wire latch_strobe;
  logic cal_start;
  logic wide_fraction_select;
  logic num_restrict_err;
  logic [NUM_W-1:0] frac_numerator;
  logic [DATA_W-1:0] factory_setting_word;
  logic [NUM_W-1:0] frac_denominator;
  logic [REFDIV_W-1:0] ref_divider;
  logic [INT_LO_W+INT_HI_W-1:0] int_divider;
  logic [PUMP_W-1:0] pump_gain;
  logic prescaler_select;
  logic output_halving_select;
  logic [DATA_W-1:0] fastlock_timeout_word;
  logic [DATA_W-1:0] power_enable_word;
  logic [DATA_W-1:0] loop_filter_vco_word;
  logic [DATA_W-1:0] crystal_divider_word;
  logic [DATA_W-1:0] misc_option_word;
  logic [DATA_W-1:0] lock_detect_option_word;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int cal_seen = 0;
  int cal_base;
  // Every numerator is legal for the divider in force when it is loaded, so the
  // restriction flag must stay low throughout.
  sfr_row_t rows [12] = '{
    '{24'h00_0082, 22'h00_0000, 1'b0}, '{24'h00_0010, 22'h00_0001, 1'b1},
    '{24'h00_3ff1, 22'h00_0001, 1'b0}, '{24'h40_0003, 22'h3f_f001, 1'b0},
    '{24'h00_0000, 22'h3f_f000, 1'b1}, '{24'h00_0212, 22'h3f_f000, 1'b0},
    '{24'h00_0080, 22'h3f_f008, 1'b1}, '{24'h00_0001, 22'h00_0008, 1'b0},
    '{24'h00_0000, 22'h00_0000, 1'b1}, '{24'hff_fffa, 22'h00_0000, 1'b0},
    '{24'h00_0003, 22'h00_0000, 1'b0}, '{24'h00_3ff1, 22'h00_0000, 1'b0}};

  sfr_host u_host (.serial_clk(serial_clk), .serial_data(serial_data),
    .latch_strobe(latch_strobe));

  sfr_regmap DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .serial_data(serial_data), .latch_strobe(latch_strobe), .cal_start(cal_start),
    .frac_numerator(frac_numerator), .frac_denominator(frac_denominator),
    .wide_fraction_select(wide_fraction_select), .ref_divider(ref_divider),
    .int_divider(int_divider), .pump_gain(pump_gain), .prescaler_select(prescaler_select),
    .output_halving_select(output_halving_select), .num_restrict_err(num_restrict_err),
    .fastlock_timeout_word(fastlock_timeout_word), .power_enable_word(power_enable_word),
    .loop_filter_vco_word(loop_filter_vco_word), .crystal_divider_word(crystal_divider_word),
    .misc_option_word(misc_option_word), .lock_detect_option_word(lock_detect_option_word),
    .factory_setting_word(factory_setting_word));

  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cal_start === 1'b1) begin
      cal_seen <= cal_seen + 1;
    end
    if (cyc == 7000) begin
      failures++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge ref_clk);
    check("numerator in reset", frac_numerator, '0);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("cal after reset", 22'(cal_seen), '0);
    // Zero numerators and low bits cleared for large dividers keep the host lawful.
    foreach (rows[i]) begin
      cal_base = cal_seen;
      u_host.send(rows[i].w);
      check("numerator", frac_numerator, rows[i].num);
      check("restrict flag", 22'(num_restrict_err), '0);
      check("cal pulses", 22'(cal_seen - cal_base), 22'(rows[i].cal));
    end
    check("wide select", 22'(wide_fraction_select), '0);
    u_host.send(24'h12_345c);
    check("factory word", 22'(factory_setting_word), 22'h01_2345);
    // Every decoded field gets a value of its own; a divider of four leaves the
    // numerator's low bits free.
    u_host.send(24'h00_1042);
    u_host.send(24'hc0_8573);
    u_host.send(24'h2a_c151);
    cal_base = cal_seen;
    u_host.send(24'h9c_5a70);
    check("numerator wide", frac_numerator, 22'h01_55a7);
    check("denominator wide", frac_denominator, 22'h05_7004);
    check("ref divider", 22'(ref_divider), 22'h00_0004);
    check("int divider", 22'(int_divider), 22'h00_039c);
    check("pump gain", 22'(pump_gain), 22'h00_0005);
    check("prescaler", 22'(prescaler_select), 22'h00_0001);
    check("halving", 22'(output_halving_select), 22'h00_0001);
    check("wide set", 22'(wide_fraction_select), 22'h00_0001);
    check("restrict wide", 22'(num_restrict_err), '0);
    check("cal wide", 22'(cal_seen - cal_base), 22'h00_0001);
    // Clearing the width bit hides the stored upper halves of both words.
    u_host.send(24'h00_8573);
    check("numerator narrow", frac_numerator, 22'h00_05a7);
    check("denominator narrow", frac_denominator, 22'h00_0004);
    check("wide clear", 22'(wide_fraction_select), '0);
    check("halving clear", 22'(output_halving_select), '0);
    for (int a = 4; a <= 9; a++) begin
      u_host.send({20'h5_a3c0 + 20'(a), 4'(a)});
    end
    check("fastlock word", 22'(fastlock_timeout_word), 22'h05_a3c4);
    check("power word", 22'(power_enable_word), 22'h05_a3c5);
    check("loop filter word", 22'(loop_filter_vco_word), 22'h05_a3c6);
    check("crystal word", 22'(crystal_divider_word), 22'h05_a3c7);
    check("misc word", 22'(misc_option_word), 22'h05_a3c8);
    check("lock detect word", 22'(lock_detect_option_word), 22'h05_a3c9);
    cal_base = cal_seen;
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("factory after reset", 22'(factory_setting_word), '0);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("cal after mid reset", 22'(cal_seen - cal_base), '0);
    end_sim();
  end
endmodule
